/* File: core/cmo_core_regs.sv */
`timescale 1ns/100ps
// Functional notes
// RULE_01 - Program store is read-only, 32K, separate space
// RULE_02 - Internal RAM has 256 read/write bytes, stack included
// RULE_03 - Accumulator and second operand form 16-bit pair
// RULE_04 - Software keeps stack below 80h, loads pointer
// RULE_05 - Program counter 16 bits, resets to FFFEh
// RULE_06 - Carry takes ALU carry, also shifts and rotates
// RULE_07 - Aux carry from bit 3 carry or bit 4
// RULE_08 - Bank bits select one of four register banks
// RULE_09 - Both bank bits set map to 18h-1Fh
// RULE_10 - Signed range flag set by ALU, cleared by instruction
// RULE_11 - Parity bit zero when accumulator ones are odd
// RULE_12 - Data pointer is 16 bits, two byte registers
// RULE_13 - Banks occupy RAM 0-31, one active at once
// RULE_14 - RAM bytes 32-47 hold 128 addressable bits
// RULE_15 - Aux RAM reached by pointer and data port, auto-increment
// RULE_16 - External moves hit aux RAM when select bit clear; data pointer moves also need DPH zero
// RULE_17 - Aux RAM moves never drive port pins
// RULE_18 - Registers only by direct address 128-255
// RULE_19 - Registers ending 0h or 8h are bit addressable
// RULE_20 - Extended control holds only bit 0
module cmo_core_regs (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire cmo_pkg::cmo_byte_req_t byte_req_i,
  output logic [7:0] byte_rdata_o,
  input wire cmo_pkg::cmo_bit_req_t bit_req_i,
  output logic bit_rdata_o,
  input wire cmo_pkg::cmo_alu_flags_t alu_flags_i,
  input wire logic clr_ovf_i,
  input wire logic mul_we_i,
  input wire logic [15:0] mul_result_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_load_val_i,
  input wire logic pc_inc_i,
  output logic [15:0] pc_o,
  output logic [7:0] code_byte_o,
  input wire logic prog_we_i,
  input wire logic [cmo_pkg::ROM_AW-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire cmo_pkg::cmo_xmov_req_t xmov_i,
  output logic [7:0] xmov_rdata_o,
  output logic xmov_hit_o,
  output logic ext_bus_req_o,
  output logic [15:0] external_data_pointer_o,
  output logic [15:0] ba_pair_o,
  output logic [7:0] psw_o,
  output logic [7:0] sp_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] sp_q, sp_d, dpl_q, dpl_d, dph_q, dph_d;
  logic [7:0] acc_q, acc_d, b_q, b_d, xptr_q, xptr_d;
  logic [6:0] psw_q, psw_d;
  logic xsel_q, xsel_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] byte_rdata_q, byte_rdata_d, xmov_rdata_q, xmov_rdata_d;
  logic bit_rdata_q, bit_rdata_d;

  logic [7:0] iram_addr, iram_a, iram_b, iram_wdata, bit_byte;
  logic iram_we, is_sfr, bit_sfr;
  logic sfr_we;
  logic [7:0] sfr_waddr, sfr_wdata, bit_src, bit_new;
  logic [7:0] xram_a, xram_b, xram_waddr, xram_wdata, xmov_addr;
  logic xram_we, port_rd, port_wr;
  logic [7:0] psw_full;

  // Parity is never stored; it follows the accumulator every cycle.
  assign psw_full = {psw_q, ~(^acc_q)}; // see RULE_11

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      cmo_pkg::SP_ADDR: r = sp_q;
      cmo_pkg::DPL_ADDR: r = dpl_q; // see RULE_12
      cmo_pkg::DPH_ADDR: r = dph_q; // see RULE_12
      cmo_pkg::PSW_ADDR: r = psw_full;
      cmo_pkg::XDATA_ADDR: r = xram_a;
      cmo_pkg::XPTR_ADDR: r = xptr_q;
      cmo_pkg::ACC_ADDR: r = acc_q;
      cmo_pkg::EXTENDED_CONTROL_ADDR: r = {7'h00, xsel_q}; // see RULE_20
      cmo_pkg::B_ADDR: r = b_q;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    iram_addr = byte_req_i.addr;
    is_sfr = 1'b0;
    case (byte_req_i.mode)
      cmo_pkg::CMO_DIRECT: begin
        is_sfr = byte_req_i.addr[7]; // see RULE_18
      end
      cmo_pkg::CMO_INDIRECT: begin
        iram_addr = byte_req_i.addr; // see RULE_02
      end
      cmo_pkg::CMO_REGISTER: begin
        // Bank 3 lands on 18h-1Fh, just above bank 2.
        iram_addr = {3'b000, psw_q[cmo_pkg::PSW_RS1-1:cmo_pkg::PSW_RS0-1],
                     byte_req_i.addr[2:0]}; // see RULE_08 see RULE_09
      end
      cmo_pkg::CMO_STACK: begin
        iram_addr = byte_req_i.wr ? sp_q + 8'h01 : sp_q; // see RULE_02
      end
      default: begin
        iram_addr = byte_req_i.addr;
      end
    endcase
  end

  // Bits 00h-7Fh live in RAM 20h-2Fh; above that, in SFRs at x0h/x8h.
  always_comb begin
    bit_sfr = bit_req_i.addr[7]; // see RULE_19
    bit_byte = bit_sfr ? {bit_req_i.addr[7:3], 3'b000}
                       : cmo_pkg::BITRAM_BASE
                         | {4'h0, bit_req_i.addr[6:3]}; // see RULE_14
    bit_src = bit_sfr ? sfr_read(bit_byte) : iram_b;
    bit_new = bit_src;
    bit_new[bit_req_i.addr[2:0]] = bit_req_i.wdata;
  end

  // ****************************************************************
  // Write steering
  // ****************************************************************
  always_comb begin
    iram_we = 1'b0;
    iram_wdata = byte_req_i.wdata;
    sfr_we = 1'b0;
    sfr_waddr = byte_req_i.addr;
    sfr_wdata = byte_req_i.wdata;
    if (byte_req_i.wr) begin
      iram_we = !is_sfr;
      sfr_we = is_sfr;
    end else if (bit_req_i.wr) begin
      iram_we = !bit_sfr;
      iram_wdata = bit_new;
      sfr_we = bit_sfr;
      sfr_waddr = bit_byte;
      sfr_wdata = bit_new;
    end
  end

  assign port_rd = byte_req_i.rd && is_sfr
                   && byte_req_i.addr == cmo_pkg::XDATA_ADDR;
  assign port_wr = sfr_we && sfr_waddr == cmo_pkg::XDATA_ADDR;

  // ****************************************************************
  // Auxiliary RAM paths
  // ****************************************************************
  always_comb begin
    xmov_addr = xmov_i.use_external_data_pointer ? dpl_q : xmov_i.ri_addr;
    xmov_hit_o = xmov_i.req && !xsel_q
                 && (!xmov_i.use_external_data_pointer || dph_q == 8'h00); // see RULE_16
    // A hit is served inside; the pins see nothing of it.
    ext_bus_req_o = xmov_i.req && !xmov_hit_o; // see RULE_17
    xram_we = port_wr || (xmov_hit_o && xmov_i.wr); // see RULE_15
    xram_waddr = port_wr ? xptr_q : xmov_addr;
    xram_wdata = port_wr ? sfr_wdata : xmov_i.wdata;
  end

  cmo_byte_ram u_iram (
    .mclk_i(mclk_i),
    .we_i(iram_we),
    .waddr_i(iram_we && !byte_req_i.wr ? bit_byte : iram_addr),
    .wdata_i(iram_wdata),
    .raddr_a_i(iram_addr),
    .raddr_b_i(bit_byte),
    .rdata_a_o(iram_a),
    .rdata_b_o(iram_b)
  );

  cmo_byte_ram u_xram (
    .mclk_i(mclk_i),
    .we_i(xram_we),
    .waddr_i(xram_waddr),
    .wdata_i(xram_wdata),
    .raddr_a_i(xptr_q),
    .raddr_b_i(xmov_addr),
    .rdata_a_o(xram_a),
    .rdata_b_o(xram_b)
  );

  cmo_prog_rom u_rom (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i),
    .prog_data_i(prog_data_i),
    .fetch_addr_i(pc_q),
    .fetch_data_o(code_byte_o)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    sp_d = sp_q;
    dpl_d = dpl_q;
    dph_d = dph_q;
    psw_d = psw_q;
    acc_d = acc_q;
    b_d = b_q;
    xsel_d = xsel_q;
    xptr_d = (port_rd || port_wr) ? xptr_q + 8'h01 : xptr_q; // see RULE_15
    if (sfr_we) begin
      case (sfr_waddr)
        cmo_pkg::SP_ADDR: sp_d = sfr_wdata;
        cmo_pkg::DPL_ADDR: dpl_d = sfr_wdata;
        cmo_pkg::DPH_ADDR: dph_d = sfr_wdata;
        cmo_pkg::PSW_ADDR: psw_d = sfr_wdata[7:1];
        cmo_pkg::XPTR_ADDR: xptr_d = sfr_wdata;
        cmo_pkg::ACC_ADDR: acc_d = sfr_wdata;
        cmo_pkg::EXTENDED_CONTROL_ADDR: xsel_d = sfr_wdata[0]; // see RULE_20
        cmo_pkg::B_ADDR: b_d = sfr_wdata;
        default: sp_d = sp_q;
      endcase
    end
    if (byte_req_i.mode == cmo_pkg::CMO_STACK) begin
      if (byte_req_i.wr) begin
        sp_d = sp_q + 8'h01;
      end else if (byte_req_i.rd) begin
        sp_d = sp_q - 8'h01;
      end
    end
    if (mul_we_i) begin
      {b_d, acc_d} = mul_result_i; // see RULE_03
    end
    // Flag updates from the ALU land after any software write.
    if (clr_ovf_i) begin
      psw_d[cmo_pkg::PSW_OV-1] = 1'b0; // see RULE_10
    end
    if (alu_flags_i.arith_we) begin
      psw_d[cmo_pkg::PSW_CY-1] = alu_flags_i.cy; // see RULE_06
      psw_d[cmo_pkg::PSW_AC-1] = alu_flags_i.ac; // see RULE_07
      if (alu_flags_i.ov) begin
        psw_d[cmo_pkg::PSW_OV-1] = 1'b1; // see RULE_10
      end else if (!clr_ovf_i) begin
        psw_d[cmo_pkg::PSW_OV-1] = 1'b0;
      end
    end else if (alu_flags_i.cy_we) begin
      psw_d[cmo_pkg::PSW_CY-1] = alu_flags_i.cy; // see RULE_06
    end
    pc_d = pc_q;
    if (pc_load_i) begin
      pc_d = pc_load_val_i;
    end else if (pc_inc_i) begin
      pc_d = pc_q + 16'h0001; // see RULE_05
    end
    byte_rdata_d = byte_rdata_q;
    if (byte_req_i.rd) begin
      byte_rdata_d = is_sfr ? sfr_read(byte_req_i.addr) : iram_a;
    end
    bit_rdata_d = bit_req_i.rd ? bit_src[bit_req_i.addr[2:0]] : bit_rdata_q;
    xmov_rdata_d = xmov_rdata_q;
    if (xmov_hit_o && !xmov_i.wr) begin
      xmov_rdata_d = xram_b;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp_q <= cmo_pkg::SP_RST;
      dpl_q <= cmo_pkg::BYTE_RST;
      dph_q <= cmo_pkg::BYTE_RST;
      psw_q <= cmo_pkg::PSW_RST;
      acc_q <= cmo_pkg::BYTE_RST;
      b_q <= cmo_pkg::BYTE_RST;
      xptr_q <= cmo_pkg::BYTE_RST;
      xsel_q <= 1'b0;
      pc_q <= cmo_pkg::PC_RST; // see RULE_05
      byte_rdata_q <= cmo_pkg::BYTE_RST;
      bit_rdata_q <= 1'b0;
      xmov_rdata_q <= cmo_pkg::BYTE_RST;
    end else begin
      sp_q <= sp_d;
      dpl_q <= dpl_d;
      dph_q <= dph_d;
      psw_q <= psw_d;
      acc_q <= acc_d;
      b_q <= b_d;
      xptr_q <= xptr_d;
      xsel_q <= xsel_d;
      pc_q <= pc_d;
      byte_rdata_q <= byte_rdata_d;
      bit_rdata_q <= bit_rdata_d;
      xmov_rdata_q <= xmov_rdata_d;
    end
  end

  assign byte_rdata_o = byte_rdata_q;
  assign bit_rdata_o = bit_rdata_q;
  assign xmov_rdata_o = xmov_rdata_q;
  assign pc_o = pc_q;
  assign external_data_pointer_o = {dph_q, dpl_q}; // see RULE_12
  assign ba_pair_o = {b_q, acc_q}; // see RULE_03
  assign psw_o = psw_full;
  assign sp_o = sp_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_port_rd;
    byte_req_i.rd && byte_req_i.mode == cmo_pkg::CMO_DIRECT
    && byte_req_i.addr == cmo_pkg::XDATA_ADDR && !sfr_we;
  endsequence

  sequence s_reg_wr;
    byte_req_i.wr && byte_req_i.mode == cmo_pkg::CMO_REGISTER;
  endsequence

  sequence s_bank_rd;
    byte_req_i.rd && !byte_req_i.wr && !bit_req_i.wr
    && byte_req_i.mode == cmo_pkg::CMO_DIRECT
    && byte_req_i.addr == {3'b000, $past(psw_q[3:2], 2),
                           $past(byte_req_i.addr[2:0], 2)};
  endsequence

  property p_pc_step;
    pc_inc_i && !pc_load_i |=> pc_o == $past(pc_o) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) // see RULE_05
    else $error("program counter did not step by one");

  property p_parity;
    psw_o[cmo_pkg::PSW_P] == ~(^ba_pair_o[7:0]);
  endproperty
  a_parity: assert property (p_parity) // see RULE_11
    else $error("parity bit disagrees with accumulator");

  property p_clear_signed_flag_instr;
    clr_ovf_i && !(alu_flags_i.arith_we && alu_flags_i.ov)
    |=> !psw_o[cmo_pkg::PSW_OV];
  endproperty
  a_clear_signed_flag_instr: assert property (p_clear_signed_flag_instr) // see RULE_10
    else $error("signed range flag not cleared");

  property p_carry;
    (alu_flags_i.arith_we || alu_flags_i.cy_we)
    |=> psw_o[cmo_pkg::PSW_CY] == $past(alu_flags_i.cy);
  endproperty
  a_carry: assert property (p_carry) // see RULE_06
    else $error("carry flag not taken from ALU");

  property p_aux;
    alu_flags_i.arith_we |=> psw_o[cmo_pkg::PSW_AC] == $past(alu_flags_i.ac);
  endproperty
  a_aux: assert property (p_aux) // see RULE_07
    else $error("aux carry flag not taken from ALU");

  property p_xptr;
    s_port_rd |=> xptr_q == $past(xptr_q) + 8'h01
                  && byte_rdata_o == $past(xram_a);
  endproperty
  a_xptr: assert property (p_xptr) // see RULE_15
    else $error("data port read did not advance pointer");

  property p_xmov_miss;
    xmov_i.req && xsel_q |-> !xmov_hit_o && ext_bus_req_o;
  endproperty
  a_xmov_miss: assert property (p_xmov_miss) // see RULE_16
    else $error("aux RAM answered with select bit set");

  property p_no_port;
    xmov_hit_o |-> !ext_bus_req_o;
  endproperty
  a_no_port: assert property (p_no_port) // see RULE_17
    else $error("aux RAM access raised a port request");

  property p_bank;
    s_reg_wr ##2 s_bank_rd |=> byte_rdata_o == $past(byte_req_i.wdata, 3);
  endproperty
  a_bank: assert property (p_bank) // see RULE_13
    else $error("register write not seen at banked RAM byte");

  property p_ba;
    mul_we_i |=> ba_pair_o == $past(mul_result_i);
  endproperty
  a_ba: assert property (p_ba) // see RULE_03
    else $error("wide result not held in register pair");

  property p_extended_control;
    byte_req_i.rd && is_sfr && byte_req_i.addr == cmo_pkg::EXTENDED_CONTROL_ADDR
    |=> byte_rdata_o[7:1] == 7'h00;
  endproperty
  a_extended_control: assert property (p_extended_control) // see RULE_20
    else $error("unused extended control bits read nonzero");
endmodule

/* File: core/cmo_pkg.sv */
package cmo_pkg;
  // ****************************************************************
  // Special function register and bit RAM addresses
  // ****************************************************************
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam logic [7:0] XDATA_ADDR = 8'hd4;
  localparam logic [7:0] XPTR_ADDR = 8'hd6;
  localparam logic [7:0] ACC_ADDR = 8'he0;
  localparam logic [7:0] EXTENDED_CONTROL_ADDR = 8'he8;
  localparam logic [7:0] B_ADDR = 8'hf0;
  localparam logic [7:0] BITRAM_BASE = 8'h20;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] PSW_RST = 7'h00;
  localparam logic [15:0] PC_RST = 16'hfffe;

  // ****************************************************************
  // Field positions and sizes
  // ****************************************************************
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;
  localparam int ROM_AW = 15;
  localparam int ROM_DEPTH = 32768;
  localparam int RAM_DEPTH = 256;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    CMO_DIRECT = 2'b00,
    CMO_INDIRECT = 2'b01,
    CMO_REGISTER = 2'b10,
    CMO_STACK = 2'b11
  } cmo_mode_t;

  typedef struct packed {
    cmo_mode_t mode;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cmo_byte_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic wdata;
  } cmo_bit_req_t;

  typedef struct packed {
    logic arith_we;
    logic cy_we;
    logic cy;
    logic ac;
    logic ov;
  } cmo_alu_flags_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic use_external_data_pointer;
    logic [7:0] ri_addr;
    logic [7:0] wdata;
  } cmo_xmov_req_t;
endpackage

/* File: core/cmo_byte_ram.sv */
`timescale 1ns/100ps
// ****************************************************************
// Byte RAM, one write port and two asynchronous read ports
// ****************************************************************
module cmo_byte_ram (
  input wire logic mclk_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_a_i,
  input wire logic [7:0] raddr_b_i,
  output logic [7:0] rdata_a_o,
  output logic [7:0] rdata_b_o
);
  logic [7:0] mem_q [cmo_pkg::RAM_DEPTH];

  // The contents are left unreset, as in any on-chip RAM.
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_a_o = mem_q[raddr_a_i];
  assign rdata_b_o = mem_q[raddr_b_i];
endmodule

/* File: core/cmo_prog_rom.sv */
`timescale 1ns/100ps
// ****************************************************************
// Program store, loaded only through the programming port
// ****************************************************************
module cmo_prog_rom (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic prog_we_i,
  input wire logic [cmo_pkg::ROM_AW-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic [15:0] fetch_addr_i,
  output logic [7:0] fetch_data_o
);
  logic [7:0] rom_q [cmo_pkg::ROM_DEPTH];
  logic [7:0] data_q;
  logic [7:0] data_d;

  // The core has no write path here; the upper half aliases the lower.
  always_ff @(posedge mclk_i) begin
    if (prog_we_i) begin // see RULE_01
      rom_q[prog_addr_i] <= prog_data_i;
    end
  end

  always_comb begin
    data_d = rom_q[fetch_addr_i[cmo_pkg::ROM_AW-1:0]]; // see RULE_01
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= cmo_pkg::BYTE_RST;
    end else begin
      data_q <= data_d;
    end
  end

  assign fetch_data_o = data_q;
endmodule

/* File: testbench/cmo_core_regs_tb.sv */
`timescale 1ns/100ps
module cmo_core_regs_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  cmo_pkg::cmo_byte_req_t byte_req_i = '0;
  cmo_pkg::cmo_bit_req_t bit_req_i = '0;
  cmo_pkg::cmo_alu_flags_t alu_flags_i = '0;
  cmo_pkg::cmo_xmov_req_t xmov_i = '0;
  logic clr_ovf_i = 1'b0;
  logic mul_we_i = 1'b0;
  logic [15:0] mul_result_i = 16'h0000;
  logic pc_load_i = 1'b0;
  logic [15:0] pc_load_val_i = 16'h0000;
  logic pc_inc_i = 1'b0;
  logic prog_we_i = 1'b0;
  logic [cmo_pkg::ROM_AW-1:0] prog_addr_i = '0;
  logic [7:0] prog_data_i = 8'h00;
  logic [7:0] byte_rdata_o;
  logic bit_rdata_o;
  logic [15:0] pc_o;
  logic [7:0] code_byte_o;
  logic [7:0] xmov_rdata_o;
  logic xmov_hit_o;
  logic ext_bus_req_o;
  logic [15:0] external_data_pointer_o;
  logic [15:0] ba_pair_o;
  logic [7:0] psw_o;
  logic [7:0] sp_o;
  int n_mismatch = 0;
  int comparisons = 0;

  cmo_core_regs dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .byte_req_i(byte_req_i), .byte_rdata_o(byte_rdata_o),
    .bit_req_i(bit_req_i), .bit_rdata_o(bit_rdata_o),
    .alu_flags_i(alu_flags_i), .clr_ovf_i(clr_ovf_i),
    .mul_we_i(mul_we_i), .mul_result_i(mul_result_i),
    .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i),
    .pc_inc_i(pc_inc_i), .pc_o(pc_o), .code_byte_o(code_byte_o),
    .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i),
    .prog_data_i(prog_data_i), .xmov_i(xmov_i),
    .xmov_rdata_o(xmov_rdata_o), .xmov_hit_o(xmov_hit_o),
    .ext_bus_req_o(ext_bus_req_o), .external_data_pointer_o(external_data_pointer_o),
    .ba_pair_o(ba_pair_o), .psw_o(psw_o), .sp_o(sp_o));

  always #5 mclk_i = ~mclk_i;

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask

  // Each access is followed by an idle cycle, so no signal is driven
  // twice in one time step and single-cycle strobes never merge.
  task automatic bop(input cmo_pkg::cmo_mode_t m, input logic [7:0] a,
                     input logic r, input logic w, input logic [7:0] d);
    byte_req_i = '{mode: m, addr: a, rd: r, wr: w, wdata: d};
    step();
    byte_req_i = '0;
    step();
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bop(cmo_pkg::CMO_DIRECT, a, 1'b0, 1'b1, d);
  endtask

  task automatic rd8(input cmo_pkg::cmo_mode_t m, input logic [7:0] a,
                     input logic [7:0] exp, input string what);
    bop(m, a, 1'b1, 1'b0, 8'h00);
    chk(what, 16'(byte_rdata_o), 16'(exp));
  endtask

  task automatic bitop(input logic [7:0] a, input logic r, input logic w,
                       input logic d);
    bit_req_i = '{addr: a, rd: r, wr: w, wdata: d};
    step();
    bit_req_i = '0;
    step();
  endtask

  task automatic xm(input logic w, input logic u, input logic [7:0] ri,
                    input logic [7:0] d, input logic hit);
    xmov_i = '{req: 1'b1, wr: w, use_external_data_pointer: u, ri_addr: ri, wdata: d};
    #1;
    chk("move hit", 16'(xmov_hit_o), 16'(hit));
    chk("pin request", 16'(ext_bus_req_o), 16'(!hit));
    step();
    xmov_i = '0;
    step();
  endtask

  task automatic alu(input logic [4:0] f, input logic clr);
    alu_flags_i = cmo_pkg::cmo_alu_flags_t'(f);
    clr_ovf_i = clr;
    step();
    alu_flags_i = '0;
    clr_ovf_i = 1'b0;
    step();
  endtask

  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    n_mismatch++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    chk("stack pointer", 16'(sp_o), 16'h0007);
    chk("program counter", pc_o, 16'hfffe);
    chk("status word", 16'(psw_o), 16'h0001);
    chk("data pointer", external_data_pointer_o, 16'h0000);
    chk("pair", ba_pair_o, 16'h0000);
    reset_n_i = 1'b1;
    step();
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::EXTENDED_CONTROL_ADDR, 8'h00, "ext ctl");
    rd8(cmo_pkg::CMO_DIRECT, 8'h85, 8'h00, "unmapped");
    wr8(cmo_pkg::DPL_ADDR, 8'h34);
    wr8(cmo_pkg::DPH_ADDR, 8'h12);
    chk("data pointer", external_data_pointer_o, 16'h1234);
    wr8(cmo_pkg::ACC_ADDR, 8'h07);
    wr8(cmo_pkg::B_ADDR, 8'ha5);
    chk("pair", ba_pair_o, 16'ha507);
    chk("parity odd", 16'(psw_o[0]), 16'h0000);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::B_ADDR, 8'ha5, "second op");
    wr8(cmo_pkg::ACC_ADDR, 8'h03);
    chk("parity even", 16'(psw_o[0]), 16'h0001);
    mul_we_i = 1'b1;
    mul_result_i = 16'hbeef;
    step();
    mul_we_i = 1'b0;
    step();
    chk("wide result", ba_pair_o, 16'hbeef);
    for (int b = 0; b < 4; b++) begin
      wr8(cmo_pkg::PSW_ADDR, 8'(b << 3));
      chk("bank bits", 16'(psw_o), 16'(b << 3));
      bop(cmo_pkg::CMO_REGISTER, 8'h05, 1'b0, 1'b1, 8'h50 + 8'(b));
      rd8(cmo_pkg::CMO_DIRECT, 8'(b * 8 + 5), 8'h50 + 8'(b),
          "bank reg");
    end
    wr8(cmo_pkg::PSW_ADDR, 8'h00);
    bop(cmo_pkg::CMO_INDIRECT, 8'hc3, 1'b0, 1'b1, 8'h5a);
    rd8(cmo_pkg::CMO_INDIRECT, 8'hc3, 8'h5a, "upper ram");
    rd8(cmo_pkg::CMO_DIRECT, 8'hc3, 8'h00, "sfr space");
    bop(cmo_pkg::CMO_STACK, 8'h00, 1'b0, 1'b1, 8'h9e);
    chk("push pointer", 16'(sp_o), 16'h0008);
    rd8(cmo_pkg::CMO_INDIRECT, 8'h08, 8'h9e, "pushed");
    rd8(cmo_pkg::CMO_STACK, 8'h00, 8'h9e, "popped");
    chk("pop pointer", 16'(sp_o), 16'h0007);
    // RAM is unreset, so clear the byte before its read-modify-write.
    wr8(8'h21, 8'h00);
    bitop(8'h0a, 1'b0, 1'b1, 1'b1);
    rd8(cmo_pkg::CMO_DIRECT, 8'h21, 8'h04, "bit ram");
    bitop(8'h0a, 1'b1, 1'b0, 1'b0);
    chk("bit read", 16'(bit_rdata_o), 16'h0001);
    bitop(8'he3, 1'b0, 1'b1, 1'b0);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::ACC_ADDR, 8'he7, "acc bit");
    bitop(8'he5, 1'b1, 1'b0, 1'b0);
    chk("sfr bit", 16'(bit_rdata_o), 16'h0001);
    // ****************************************************************
    // Aux RAM through the port and through external moves
    // ****************************************************************
    wr8(cmo_pkg::XPTR_ADDR, 8'h10);
    wr8(cmo_pkg::XDATA_ADDR, 8'haa);
    wr8(cmo_pkg::XDATA_ADDR, 8'hbb);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::XPTR_ADDR, 8'h12, "ptr");
    wr8(cmo_pkg::XPTR_ADDR, 8'h10);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::XDATA_ADDR, 8'haa, "aux");
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::XDATA_ADDR, 8'hbb, "aux");
    wr8(cmo_pkg::DPH_ADDR, 8'h00);
    wr8(cmo_pkg::DPL_ADDR, 8'h11);
    xm(1'b0, 1'b1, 8'h00, 8'h00, 1'b1);
    chk("move read", 16'(xmov_rdata_o), 16'h00bb);
    xm(1'b1, 1'b0, 8'h20, 8'h5c, 1'b1);
    wr8(cmo_pkg::XPTR_ADDR, 8'h20);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::XDATA_ADDR, 8'h5c, "moved");
    wr8(cmo_pkg::DPH_ADDR, 8'h01);
    xm(1'b0, 1'b1, 8'h00, 8'h00, 1'b0);
    wr8(cmo_pkg::EXTENDED_CONTROL_ADDR, 8'hff);
    rd8(cmo_pkg::CMO_DIRECT, cmo_pkg::EXTENDED_CONTROL_ADDR, 8'h01, "ext ctl");
    xm(1'b0, 1'b0, 8'h20, 8'h00, 1'b0);
    // ****************************************************************
    // Status flags and program counter
    // ****************************************************************
    alu(5'h17, 1'b0);
    chk("flags", 16'({psw_o[7:6], psw_o[2]}), 16'h0007);
    alu(5'h00, 1'b1);
    chk("flags", 16'({psw_o[7:6], psw_o[2]}), 16'h0006);
    alu(5'h10, 1'b0);
    chk("flags", 16'({psw_o[7:6], psw_o[2]}), 16'h0000);
    alu(5'h0c, 1'b0);
    chk("flags", 16'({psw_o[7:6], psw_o[2]}), 16'h0004);
    pc_inc_i = 1'b1;
    step();
    pc_inc_i = 1'b0;
    chk("pc inc", pc_o, 16'hffff);
    prog_we_i = 1'b1;
    prog_addr_i = 15'h0010;
    prog_data_i = 8'h3c;
    step();
    prog_we_i = 1'b0;
    pc_load_i = 1'b1;
    pc_inc_i = 1'b1;
    pc_load_val_i = 16'h0010;
    step();
    pc_load_i = 1'b0;
    pc_inc_i = 1'b0;
    chk("pc load", pc_o, 16'h0010);
    step();
    chk("code byte", 16'(code_byte_o), 16'h003c);
    print_verdict();
  end
endmodule
